//--- src/rcsf_framer.sv
// Summary of operation
// - Type 0x17 carries a remote configuration request.
// - Frame identifier zero suppresses every reply frame.
// - Options bit 0x02 asks immediate apply remotely.
// - Remote command name sits at offsets 16-17.
// - No parameter bytes means query, not write.
// - Parameter values travel as raw binary bytes.
// - Local command types 0x08/0x09 get 0x88 reply.
// - One request may produce several response frames.
// - Response echoes the request command name.
// - Status byte: ok, error, unknown, bad, failure.
// - Data follows status only for query requests.
// - Internal events emit unsolicited 0x8A status frame.
// - Codes 0x00/0x01: hardware and watchdog reset.
// - Codes 0x02/0x06 associate, 0x03 disassociate.
// - Codes 0x0B wake, 0x0C sleep, 0x0D overvoltage.
// - Power-up always emits hardware reset status frame.
// - Checksum is 0xFF minus low byte sum.
`include "rcsf_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module rcsf_framer (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_byte_i,
  output logic tx_valid_o,
  output logic [7:0] tx_byte_o,
  input wire logic tx_ready_i,
  output logic cmd_valid_o,
  output logic rmt_valid_o,
  output logic frm_err_o,
  output logic [7:0] cmd_type_o,
  output logic [7:0] cmd_fid_o,
  output logic [15:0] cmd_name_o,
  output logic [63:0] cmd_par_o,
  output logic [3:0] cmd_plen_o,
  output logic [63:0] rmt_addr_o,
  output logic rmt_apply_o,
  input wire logic rsp_valid_i,
  output logic rsp_ready_o,
  input wire logic [2:0] rsp_status_i,
  input wire logic [63:0] rsp_data_i,
  input wire logic [3:0] rsp_dlen_i,
  input wire logic [7:0] sts_evt_i
);
  rcsf_pkg::rcsf_state_t st_ff;
  rcsf_pkg::rcsf_state_t nxt_st;
  logic [7:0] rx_sum;
  logic [7:0] tx_sum;
  logic rx_clr;
  logic rx_add;
  logic tx_clr;
  logic tx_add;
  logic tx_acc;
  logic [7:0] pend;
  logic [7:0] pend_clr;
  logic [2:0] sel;
  logic [15:0] len_rx;
  logic [15:0] name_ofs;
  logic [15:0] par_ofs;
  logic is_rmt;
  logic is_loc;
  logic rsp_drop;

  // ============================================================
  // Byte of the frame body at a given index.
  function automatic logic [7:0] body_byte(
    input rcsf_pkg::rcsf_state_t s,
    input logic [3:0] i
  );
    logic [3:0] sh;
    sh = 4'(s.dlen - 4'(i - `RCSF_B_DATA) - 4'h1);
    body_byte = '0;
    if (!s.kind) begin
      if (i == `RCSF_B_TYPE) begin
        body_byte = `RCSF_T_STS;
      end else begin
        body_byte = s.code;
      end
    end else begin
      case (i)
        `RCSF_B_TYPE: body_byte = `RCSF_T_RSP;
        `RCSF_B_FID: body_byte = s.rfid;
        `RCSF_B_NHI: body_byte = s.rname[15:8];
        `RCSF_B_NLO: body_byte = s.rname[7:0];
        `RCSF_B_STAT: body_byte = 8'(s.rstat);
        default: body_byte = s.rdata[{sh[2:0], 3'b000} +: 8];
      endcase
    end
  endfunction

  // ============================================================
  // Status code sent for each event bit.
  function automatic logic [7:0] code_of(input logic [2:0] b);
    case (b)
      3'h0: code_of = `RCSF_ST_HWRST;
      3'h1: code_of = `RCSF_ST_WDT;
      3'h2: code_of = `RCSF_ST_ASSOC;
      3'h3: code_of = `RCSF_ST_DISAS;
      3'h4: code_of = `RCSF_ST_ASSOC2;
      3'h5: code_of = `RCSF_ST_WAKE;
      3'h6: code_of = `RCSF_ST_SLEEP;
      default: code_of = `RCSF_ST_OVOLT;
    endcase
  endfunction

  // ============================================================
  // Checksum accumulators for the receive and send paths.
  rcsf_cksum u_rx_ck (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .clr_i(rx_clr),
    .add_i(rx_add),
    .byte_i(rx_byte_i),
    .sum_o(rx_sum)
  );

  rcsf_cksum u_tx_ck (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .clr_i(tx_clr),
    .add_i(tx_add),
    .byte_i(st_ff.txb),
    .sum_o(tx_sum)
  );

  // Pending status events; hardware reset is pending out of reset.
  rcsf_sticky #(
    .INIT(`RCSF_STS_INIT)
  ) u_pend (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .set_i(sts_evt_i),
    .clr_i(pend_clr),
    .q_o(pend)
  );

  // ============================================================
  // Field placement depends on the frame type caught at offset 3.
  assign is_rmt = (st_ff.typ == `RCSF_T_RCMD);
  assign is_loc = (st_ff.typ == `RCSF_T_LCMD) ||
                  (st_ff.typ == `RCSF_T_LCMDQ);
  assign name_ofs = is_rmt ? `RCSF_O_RNAME : `RCSF_O_LNAME;
  assign par_ofs = is_rmt ? `RCSF_O_RPAR : `RCSF_O_LPAR;
  assign len_rx = {st_ff.last[7:0], rx_byte_i};
  assign tx_acc = st_ff.txv && tx_ready_i;
  assign rx_clr = rx_valid_i && (st_ff.rst == rcsf_pkg::RCSF_RX_LENL);
  assign rx_add = rx_valid_i && (st_ff.rst == rcsf_pkg::RCSF_RX_BODY);
  assign tx_clr = tx_acc && (st_ff.tst == rcsf_pkg::RCSF_TX_LL);
  assign tx_add = tx_acc && (st_ff.tst == rcsf_pkg::RCSF_TX_BODY);
  // Without a live request or with identifier zero, replies vanish.
  assign rsp_drop = !st_ff.lseen || (st_ff.lfid == '0);

  // Lowest pending bit goes first, so a reset report leads.
  always_comb begin
    sel = '0;
    for (int i = 7; i >= 0; i--) begin
      if (pend[i]) begin
        sel = 3'(i);
      end
    end
  end

  // ============================================================
  // Next state: parser, response intake and frame sender.
  always_comb begin
    nxt_st = st_ff;
    pend_clr = '0;
    nxt_st.cmd_valid = 1'b0;
    nxt_st.rmt_valid = 1'b0;
    nxt_st.frm_err = 1'b0;

    // Receive parser; every byte is taken, there is no stall.
    if (rx_valid_i) begin
      case (st_ff.rst)
        rcsf_pkg::RCSF_RX_IDLE: begin
          if (rx_byte_i == `RCSF_DELIM) begin
            nxt_st.rst = rcsf_pkg::RCSF_RX_LENH;
          end
        end
        rcsf_pkg::RCSF_RX_LENH: begin
          nxt_st.last = {8'h00, rx_byte_i};
          nxt_st.rst = rcsf_pkg::RCSF_RX_LENL;
        end
        rcsf_pkg::RCSF_RX_LENL: begin
          // Length counts type through payload; keep last offset.
          nxt_st.last = len_rx + `RCSF_LAST_ADJ;
          nxt_st.ofs = `RCSF_O_TYPE;
          nxt_st.plen = '0;
          nxt_st.par = '0;
          nxt_st.typ = '0;
          if (len_rx == '0) begin
            nxt_st.rst = rcsf_pkg::RCSF_RX_IDLE;
          end else begin
            nxt_st.rst = rcsf_pkg::RCSF_RX_BODY;
          end
        end
        rcsf_pkg::RCSF_RX_BODY: begin
          if (st_ff.ofs == `RCSF_O_TYPE) begin
            nxt_st.typ = rx_byte_i;
          end
          if (st_ff.ofs == `RCSF_O_FID) begin
            nxt_st.fid = rx_byte_i;
          end
          if (is_rmt && st_ff.ofs >= `RCSF_O_ADDR_F &&
              st_ff.ofs <= `RCSF_O_ADDR_L) begin
            nxt_st.addr = {st_ff.addr[55:0], rx_byte_i};
          end
          if (is_rmt && st_ff.ofs == `RCSF_O_OPTS) begin
            nxt_st.opts = rx_byte_i;
          end
          if (st_ff.ofs == name_ofs) begin
            nxt_st.name[15:8] = rx_byte_i;
          end
          if (st_ff.ofs == name_ofs + 16'h0001) begin
            nxt_st.name[7:0] = rx_byte_i;
          end
          // Binary parameter, right aligned; bytes past eight drop.
          if (st_ff.ofs >= par_ofs && st_ff.plen != `RCSF_PAR_MAX) begin
            nxt_st.par = {st_ff.par[55:0], rx_byte_i};
            nxt_st.plen = st_ff.plen + 4'h1;
          end
          if (st_ff.ofs == st_ff.last) begin
            nxt_st.rst = rcsf_pkg::RCSF_RX_CSUM;
          end else begin
            nxt_st.ofs = st_ff.ofs + 16'h0001;
          end
        end
        rcsf_pkg::RCSF_RX_CSUM: begin
          nxt_st.rst = rcsf_pkg::RCSF_RX_IDLE;
          if (8'(rx_sum + rx_byte_i) != `RCSF_CK_GOOD) begin
            nxt_st.frm_err = 1'b1;
          end else if (st_ff.last > name_ofs) begin
            if (is_loc) begin
              nxt_st.cmd_valid = 1'b1;
              nxt_st.lfid = st_ff.fid;
              nxt_st.lname = st_ff.name;
              nxt_st.lquery = (st_ff.plen == '0);
              nxt_st.lseen = 1'b1;
            end else if (is_rmt) begin
              nxt_st.rmt_valid = 1'b1;
            end
          end
        end
        default: nxt_st.rst = rcsf_pkg::RCSF_RX_IDLE;
      endcase
    end

    // Response intake; the core may answer one request many times.
    if (rsp_valid_i && st_ff.rrdy && !rsp_drop) begin
      nxt_st.rhold = 1'b1;
      nxt_st.rrdy = 1'b0;
      nxt_st.rfid = st_ff.lfid;
      nxt_st.rname = st_ff.lname;
      nxt_st.rstat = rsp_status_i;
      nxt_st.rdata = rsp_data_i;
      // A write gets no data bytes; data is capped at eight.
      if (!st_ff.lquery) begin
        nxt_st.dlen = '0;
      end else if (rsp_dlen_i > `RCSF_PAR_MAX) begin
        nxt_st.dlen = `RCSF_PAR_MAX;
      end else begin
        nxt_st.dlen = rsp_dlen_i;
      end
    end

    // Sender; every byte stands until the link takes it.
    case (st_ff.tst)
      rcsf_pkg::RCSF_TX_IDLE: begin
        if (pend != '0) begin
          pend_clr = 8'h01 << sel;
          nxt_st.kind = 1'b0;
          nxt_st.code = code_of(sel);
          nxt_st.blen = `RCSF_STS_LEN;
          nxt_st.txv = 1'b1;
          nxt_st.txb = `RCSF_DELIM;
          nxt_st.tst = rcsf_pkg::RCSF_TX_DLM;
        end else if (st_ff.rhold) begin
          nxt_st.kind = 1'b1;
          nxt_st.blen = `RCSF_RSP_HDR + st_ff.dlen;
          nxt_st.txv = 1'b1;
          nxt_st.txb = `RCSF_DELIM;
          nxt_st.tst = rcsf_pkg::RCSF_TX_DLM;
        end
      end
      rcsf_pkg::RCSF_TX_DLM: begin
        if (tx_acc) begin
          nxt_st.txb = `RCSF_LEN_HI;
          nxt_st.tst = rcsf_pkg::RCSF_TX_LH;
        end
      end
      rcsf_pkg::RCSF_TX_LH: begin
        if (tx_acc) begin
          nxt_st.txb = 8'(st_ff.blen);
          nxt_st.tst = rcsf_pkg::RCSF_TX_LL;
        end
      end
      rcsf_pkg::RCSF_TX_LL: begin
        if (tx_acc) begin
          nxt_st.idx = '0;
          nxt_st.txb = body_byte(st_ff, `RCSF_B_TYPE);
          nxt_st.tst = rcsf_pkg::RCSF_TX_BODY;
        end
      end
      rcsf_pkg::RCSF_TX_BODY: begin
        if (tx_acc) begin
          if (st_ff.idx == st_ff.blen - 4'h1) begin
            nxt_st.txb = `RCSF_CK_GOOD - 8'(tx_sum + st_ff.txb);
            nxt_st.tst = rcsf_pkg::RCSF_TX_CS;
          end else begin
            nxt_st.idx = st_ff.idx + 4'h1;
            nxt_st.txb = body_byte(st_ff, st_ff.idx + 4'h1);
          end
        end
      end
      rcsf_pkg::RCSF_TX_CS: begin
        if (tx_acc) begin
          nxt_st.txv = 1'b0;
          nxt_st.tst = rcsf_pkg::RCSF_TX_IDLE;
          if (st_ff.kind) begin
            nxt_st.rhold = 1'b0;
            nxt_st.rrdy = 1'b1;
          end
        end
      end
      default: begin
        nxt_st.txv = 1'b0;
        nxt_st.tst = rcsf_pkg::RCSF_TX_IDLE;
      end
    endcase

    // Synchronous reset: all quiet, ready for a response.
    if (reset_i) begin
      nxt_st = '0;
      nxt_st.rrdy = 1'b1;
    end
  end

  // State register.
  always_ff @(posedge ref_clk_i) begin
    st_ff <= nxt_st;
  end

  // ============================================================
  // Outputs straight from the state register.
  assign tx_valid_o = st_ff.txv;
  assign tx_byte_o = st_ff.txb;
  assign cmd_valid_o = st_ff.cmd_valid;
  assign rmt_valid_o = st_ff.rmt_valid;
  assign frm_err_o = st_ff.frm_err;
  assign cmd_type_o = st_ff.typ;
  assign cmd_fid_o = st_ff.fid;
  assign cmd_name_o = st_ff.name;
  assign cmd_par_o = st_ff.par;
  assign cmd_plen_o = st_ff.plen;
  assign rmt_addr_o = st_ff.addr;
  assign rmt_apply_o = (st_ff.opts & `RCSF_OPT_APPLY) != '0;
  assign rsp_ready_o = st_ff.rrdy;
endmodule
`default_nettype wire

//--- src/rcsf_defs.svh
`ifndef RCSF_DEFS_SVH
`define RCSF_DEFS_SVH
// ============================================================
// Frame framing bytes and frame type codes.
`define RCSF_DELIM 8'h7e
`define RCSF_T_LCMD 8'h08
`define RCSF_T_LCMDQ 8'h09
`define RCSF_T_RCMD 8'h17
`define RCSF_T_RSP 8'h88
`define RCSF_T_STS 8'h8a
`define RCSF_CK_GOOD 8'hff
`define RCSF_LEN_HI 8'h00
// ============================================================
// Receive byte offsets, counted from the start delimiter.
`define RCSF_O_TYPE 16'h0003
`define RCSF_O_FID 16'h0004
`define RCSF_O_ADDR_F 16'h0005
`define RCSF_O_ADDR_L 16'h000c
`define RCSF_O_OPTS 16'h000f
`define RCSF_O_RNAME 16'h0010
`define RCSF_O_RPAR 16'h0012
`define RCSF_O_LNAME 16'h0005
`define RCSF_O_LPAR 16'h0007
`define RCSF_LAST_ADJ 16'h0002
`define RCSF_OPT_APPLY 8'h02
`define RCSF_PAR_MAX 4'h8
// ============================================================
// Transmit body indices, counted from the frame type byte.
`define RCSF_B_TYPE 4'h0
`define RCSF_B_FID 4'h1
`define RCSF_B_CODE 4'h1
`define RCSF_B_NHI 4'h2
`define RCSF_B_NLO 4'h3
`define RCSF_B_STAT 4'h4
`define RCSF_B_DATA 4'h5
`define RCSF_STS_LEN 4'h2
`define RCSF_RSP_HDR 4'h5
// ============================================================
// Unsolicited status codes, by event bit.
`define RCSF_ST_HWRST 8'h00
`define RCSF_ST_WDT 8'h01
`define RCSF_ST_ASSOC 8'h02
`define RCSF_ST_DISAS 8'h03
`define RCSF_ST_ASSOC2 8'h06
`define RCSF_ST_WAKE 8'h0b
`define RCSF_ST_SLEEP 8'h0c
`define RCSF_ST_OVOLT 8'h0d
`define RCSF_STS_INIT 8'h01
`endif

//--- src/rcsf_pkg.sv
package rcsf_pkg;
  // ============================================================
  // Parser and sender states, Gray coded along the normal path.
  typedef enum logic [2:0] {
    RCSF_RX_IDLE = 3'h0,
    RCSF_RX_LENH = 3'h1,
    RCSF_RX_LENL = 3'h3,
    RCSF_RX_BODY = 3'h2,
    RCSF_RX_CSUM = 3'h6
  } rcsf_rx_st_t;

  typedef enum logic [2:0] {
    RCSF_TX_IDLE = 3'h0,
    RCSF_TX_DLM = 3'h1,
    RCSF_TX_LH = 3'h3,
    RCSF_TX_LL = 3'h2,
    RCSF_TX_BODY = 3'h6,
    RCSF_TX_CS = 3'h7
  } rcsf_tx_st_t;

  // ============================================================
  // Whole state of the framer.
  typedef struct packed {
    rcsf_rx_st_t rst;
    logic [15:0] ofs;
    logic [15:0] last;
    logic [7:0] typ;
    logic [7:0] fid;
    logic [63:0] addr;
    logic [7:0] opts;
    logic [15:0] name;
    logic [63:0] par;
    logic [3:0] plen;
    logic cmd_valid;
    logic rmt_valid;
    logic frm_err;
    logic [7:0] lfid;
    logic [15:0] lname;
    logic lquery;
    logic lseen;
    rcsf_tx_st_t tst;
    logic [3:0] idx;
    logic kind;
    logic [7:0] code;
    logic [3:0] blen;
    logic [7:0] rfid;
    logic [15:0] rname;
    logic [2:0] rstat;
    logic [63:0] rdata;
    logic [3:0] dlen;
    logic rhold;
    logic rrdy;
    logic txv;
    logic [7:0] txb;
  } rcsf_state_t;

  typedef struct packed {
    logic [7:0] sum;
  } rcsf_ck_t;

  typedef struct packed {
    logic [7:0] q;
  } rcsf_stk_t;
endpackage

//--- src/rcsf_cksum.sv
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// Running byte sum for one frame body.
module rcsf_cksum (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic clr_i,
  input wire logic add_i,
  input wire logic [7:0] byte_i,
  output logic [7:0] sum_o
);
  rcsf_pkg::rcsf_ck_t st_ff;
  rcsf_pkg::rcsf_ck_t nxt_st;

  // Clear wins over add; a cleared sum starts the next frame.
  always_comb begin
    nxt_st = st_ff;
    if (clr_i) begin
      nxt_st.sum = '0;
    end else if (add_i) begin
      nxt_st.sum = 8'(st_ff.sum + byte_i);
    end
    if (reset_i) begin
      nxt_st = '0;
    end
  end

  // State register.
  always_ff @(posedge ref_clk_i) begin
    st_ff <= nxt_st;
  end

  assign sum_o = st_ff.sum;
endmodule
`default_nettype wire

//--- src/rcsf_sticky.sv
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// Sticky event flags with a reset pattern.
module rcsf_sticky #(
  parameter logic [7:0] INIT = '0
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [7:0] set_i,
  input wire logic [7:0] clr_i,
  output logic [7:0] q_o
);
  rcsf_pkg::rcsf_stk_t st_ff;
  rcsf_pkg::rcsf_stk_t nxt_st;

  // Set wins over clear, so an event in the clearing cycle survives.
  always_comb begin
    nxt_st.q = (st_ff.q & ~clr_i) | set_i;
    if (reset_i) begin
      nxt_st.q = INIT;
    end
  end

  // State register.
  always_ff @(posedge ref_clk_i) begin
    st_ff <= nxt_st;
  end

  assign q_o = st_ff.q;
endmodule
`default_nettype wire

//--- tb/rcsf_framer_props.sv
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// Port checker for the framer; one clock domain only.
module rcsf_framer_props (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic tx_valid_o,
  input wire logic [7:0] tx_byte_o,
  input wire logic tx_ready_i,
  input wire logic cmd_valid_o,
  input wire logic rmt_valid_o,
  input wire logic frm_err_o,
  input wire logic [7:0] cmd_type_o,
  input wire logic [3:0] cmd_plen_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  // A stalled byte must not change, or the host sees a torn frame.
  a_tx_hold: assert property (
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_byte_o))
    else $error("send byte changed while stalled");
  a_tx_start: assert property (
    $rose(tx_valid_o) |-> tx_byte_o == 8'h7e)
    else $error("frame did not open with delimiter");
  a_pwr_frame: assert property (
    $fell(reset_i) |-> ##[1:2] (tx_valid_o && tx_byte_o == 8'h7e))
    else $error("no status frame after reset");
  a_cmd_pulse: assert property (
    cmd_valid_o |=> !cmd_valid_o)
    else $error("command pulse too long");
  a_cmd_type: assert property (
    cmd_valid_o |-> cmd_type_o inside {8'h08, 8'h09})
    else $error("local command with wrong type");
  a_rmt_type: assert property (
    rmt_valid_o |-> cmd_type_o == 8'h17 && !cmd_valid_o)
    else $error("remote request with wrong type");
  a_err_alone: assert property (
    frm_err_o |-> !cmd_valid_o && !rmt_valid_o)
    else $error("bad frame was forwarded");
  a_plen_cap: assert property (
    cmd_valid_o || rmt_valid_o |-> cmd_plen_o <= 4'h8)
    else $error("parameter count above eight");
  c_local: cover property (cmd_valid_o);
  c_remote: cover property (rmt_valid_o);
  c_bad: cover property (frm_err_o);
  c_stall: cover property (tx_valid_o && !tx_ready_i);
endmodule

bind rcsf_framer rcsf_framer_props rcsf_framer_props_inst (
  .ref_clk_i(ref_clk_i), .reset_i(reset_i), .tx_valid_o(tx_valid_o),
  .tx_byte_o(tx_byte_o), .tx_ready_i(tx_ready_i),
  .cmd_valid_o(cmd_valid_o), .rmt_valid_o(rmt_valid_o),
  .frm_err_o(frm_err_o), .cmd_type_o(cmd_type_o),
  .cmd_plen_o(cmd_plen_o));
`default_nettype wire

//--- tb/rcsf_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// Host side of the send link: takes bytes, slowly if asked.
module rcsf_host_model (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic slow_i,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_byte_i,
  output logic tx_ready_o,
  output logic got_o,
  output logic [7:0] got_byte_o
);
  logic [1:0] cnt_ff;
  // Slow mode takes one byte in four, so every stall path is used.
  always_ff @(posedge ref_clk_i) begin
    cnt_ff <= reset_i ? 2'h0 : cnt_ff + 2'h1;
    got_o <= tx_valid_i && tx_ready_o;
    got_byte_o <= tx_byte_i;
  end
  assign tx_ready_o = !slow_i || cnt_ff == 2'h3;
endmodule
`default_nettype wire

//--- tb/rcsf_framer_tb.sv
`timescale 1ns/100ps
`default_nettype none
module rcsf_framer_tb;
  typedef logic [7:0] rcsf_bq_t[$];
  typedef struct {
    logic [7:0] ty;
    logic [7:0] fid;
    logic [15:0] nm;
    int np;
    logic [63:0] par;
  } rcsf_row_t;
  logic ref_clk_i, reset_i, rx_valid_i, tx_valid_o, tx_ready_i, slow;
  logic cmd_valid_o, rmt_valid_o, frm_err_o, rmt_apply_o, got;
  logic rsp_valid_i, rsp_ready_o;
  logic [7:0] rx_byte_i, tx_byte_o, cmd_type_o, cmd_fid_o, sts_evt_i;
  logic [7:0] got_byte;
  logic [15:0] cmd_name_o;
  logic [63:0] cmd_par_o, rmt_addr_o, rsp_data_i;
  logic [3:0] cmd_plen_o, rsp_dlen_i;
  logic [2:0] rsp_status_i;
  rcsf_bq_t txq, f;
  rcsf_row_t rows[4];
  logic [7:0] codes[8];
  int n_mismatch, n_tests, cyc, r, k;

  rcsf_framer rcsf_framer_inst (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .rx_valid_i(rx_valid_i),
    .rx_byte_i(rx_byte_i), .tx_valid_o(tx_valid_o), .tx_byte_o(tx_byte_o),
    .tx_ready_i(tx_ready_i), .cmd_valid_o(cmd_valid_o),
    .rmt_valid_o(rmt_valid_o), .frm_err_o(frm_err_o),
    .cmd_type_o(cmd_type_o), .cmd_fid_o(cmd_fid_o),
    .cmd_name_o(cmd_name_o), .cmd_par_o(cmd_par_o),
    .cmd_plen_o(cmd_plen_o), .rmt_addr_o(rmt_addr_o),
    .rmt_apply_o(rmt_apply_o), .rsp_valid_i(rsp_valid_i),
    .rsp_ready_o(rsp_ready_o), .rsp_status_i(rsp_status_i),
    .rsp_data_i(rsp_data_i), .rsp_dlen_i(rsp_dlen_i),
    .sts_evt_i(sts_evt_i));
  rcsf_host_model rcsf_host_model_inst (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .slow_i(slow),
    .tx_valid_i(tx_valid_o), .tx_byte_i(tx_byte_o),
    .tx_ready_o(tx_ready_i), .got_o(got), .got_byte_o(got_byte));

  // ============================================================
  // Clock, capture of sent bytes and the hang guard.
  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    if (got === 1'b1) txq.push_back(got_byte);
    cyc++;
    if (cyc == 8000) begin
      n_mismatch++;
      results();
    end
  end

  // ============================================================
  // Helpers.
  task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results();
    if (n_mismatch == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Wraps a body in delimiter, length and checksum.
  function automatic rcsf_bq_t frame(rcsf_bq_t b);
    rcsf_bq_t q;
    logic [7:0] s;
    s = 8'h00;
    foreach (b[i]) s = s + b[i];
    q = b;
    q.push_front(8'(b.size()));
    q.push_front(8'h00);
    q.push_front(8'h7e);
    q.push_back(8'hff - s);
    return q;
  endfunction
  task automatic send(rcsf_bq_t q);
    foreach (q[i]) begin
      @(posedge ref_clk_i);
      rx_valid_i <= 1'b1;
      rx_byte_i <= q[i];
    end
    @(posedge ref_clk_i);
    rx_valid_i <= 1'b0;
  endtask
  // The pulse stands in the cycle after the edge that takes the checksum.
  // That edge is the one send returns on, so look before waiting again.
  task automatic wait_pulse();
    for (int i = 0; i < 3; i++) begin
      #1;
      if ((cmd_valid_o | rmt_valid_o | frm_err_o) === 1'b1) break;
      @(posedge ref_clk_i);
    end
  endtask
  task automatic rsp(logic [2:0] st, logic [63:0] d, logic [3:0] n);
    @(posedge ref_clk_i);
    rsp_valid_i <= 1'b1;
    rsp_status_i <= st;
    rsp_data_i <= d;
    rsp_dlen_i <= n;
    for (int i = 0; i < 200; i++) begin
      @(negedge ref_clk_i);
      if (rsp_ready_o === 1'b1) break;
    end
    @(posedge ref_clk_i);
    rsp_valid_i <= 1'b0;
  endtask
  task automatic expect_frame(rcsf_bq_t b);
    rcsf_bq_t e;
    e = frame(b);
    for (int i = 0; i < 300 && txq.size() < e.size(); i++)
      @(posedge ref_clk_i);
    chk("tx_count", txq.size() >= e.size(), 1'b1);
    foreach (e[i]) begin
      if (txq.size() > 0) begin
        chk("tx_byte", txq.pop_front(), e[i]);
      end
    end
  endtask

  // ============================================================
  // Main sequence.
  initial begin
    reset_i = 1'b1;
    rx_valid_i = 1'b0;
    rx_byte_i = 8'h00;
    rsp_valid_i = 1'b0;
    rsp_status_i = 3'h0;
    rsp_data_i = 64'h0;
    rsp_dlen_i = 4'h0;
    sts_evt_i = 8'h00;
    slow = 1'b1;
    rows = '{'{8'h09, 8'h02, 16'h4e49, 2, 64'h1234},
             '{8'h08, 8'h03, 16'h504c, 8, 64'h0102030405060708},
             '{8'h08, 8'h04, 16'h4448, 1, 64'h5a},
             '{8'h08, 8'h05, 16'h4244, 0, 64'h0}};
    codes = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h06, 8'h0b, 8'h0c, 8'h0d};
    repeat (20) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    for (r = 0; r < 4; r++) begin
      f = {rows[r].ty, rows[r].fid, rows[r].nm[15:8], rows[r].nm[7:0]};
      for (k = rows[r].np - 1; k >= 0; k--) f.push_back(rows[r].par[8*k+:8]);
      send(frame(f));
      wait_pulse();
      chk("cmd_valid", cmd_valid_o, 1'b1);
      chk("cmd_type", cmd_type_o, rows[r].ty);
      chk("cmd_fid", cmd_fid_o, rows[r].fid);
      chk("cmd_name", cmd_name_o, rows[r].nm);
      chk("cmd_plen", cmd_plen_o, rows[r].np);
      chk("cmd_par", cmd_par_o, rows[r].par);
    end
    expect_frame({8'h8a, 8'h00});
    // Two answers to the last query, taken while the host stalls.
    rsp(3'h0, 64'h1234, 4'h2);
    rsp(3'h4, 64'h0, 4'h0);
    expect_frame({8'h88, 8'h05, 8'h42, 8'h44, 8'h00, 8'h12, 8'h34});
    expect_frame({8'h88, 8'h05, 8'h42, 8'h44, 8'h04});
    // A write gets no data back even when the core offers some.
    send(frame({8'h08, 8'h06, 8'h4e, 8'h49, 8'h07}));
    wait_pulse();
    rsp(3'h3, 64'hff, 4'h1);
    expect_frame({8'h88, 8'h06, 8'h4e, 8'h49, 8'h03});
    send(frame({8'h08, 8'h00, 8'h42, 8'h44}));
    wait_pulse();
    rsp(3'h0, 64'h1, 4'h1);
    repeat (40) @(posedge ref_clk_i);
    chk("quiet_fid0", txq.size(), 0);
    send(frame({8'h17, 8'h01, 8'h00, 8'h13, 8'ha2, 8'h00, 8'h40, 8'h40,
      8'h11, 8'h22, 8'hff, 8'hfe, 8'h02, 8'h42, 8'h48, 8'h01}));
    wait_pulse();
    chk("rmt_valid", rmt_valid_o, 1'b1);
    chk("rmt_addr", rmt_addr_o, 64'h0013a20040401122);
    chk("rmt_apply", rmt_apply_o, 1'b1);
    chk("rmt_name", cmd_name_o, 16'h4248);
    chk("rmt_par", {cmd_plen_o, cmd_par_o[7:0]}, 12'h101);
    // Corrupt checksum, then stray byte before a good frame.
    f = frame({8'h08, 8'h07, 8'h42, 8'h44});
    f[7] = ~f[7];
    send(f);
    wait_pulse();
    chk("frm_err", frm_err_o, 1'b1);
    f = frame({8'h08, 8'h08, 8'h42, 8'h44});
    f.push_front(8'h55);
    send(f);
    wait_pulse();
    chk("resync_fid", {cmd_valid_o, cmd_fid_o}, 9'h108);
    @(posedge ref_clk_i);
    slow <= 1'b0;
    for (r = 0; r < 8; r++) begin
      @(posedge ref_clk_i);
      sts_evt_i <= 8'h01 << r;
      @(posedge ref_clk_i);
      sts_evt_i <= 8'h00;
      expect_frame({8'h8a, codes[r]});
    end
    // A second reset in mid-run must announce itself again.
    @(posedge ref_clk_i);
    reset_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    txq.delete();
    reset_i <= 1'b0;
    expect_frame({8'h8a, 8'h00});
    results();
  end
endmodule
`default_nettype wire
